// file: design/csbf_pkg.sv
// Shared constants and types for the compare, skip and branch flow unit
package csbf_pkg;

  // ***************************************************
  // Widths
  // ***************************************************
  localparam int PC_W   = 16;
  localparam int DATA_W = 8;
  localparam int OFF_W  = 7;
  localparam int ADDR_W = 2;
  localparam int CNT_W  = 3;

  // ***************************************************
  // Status flag bit positions
  // ***************************************************
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // ***************************************************
  // Register offsets and reset values
  // ***************************************************
  localparam logic [ADDR_W-1:0] REG_FLAGS = 2'h0;
  localparam logic [ADDR_W-1:0] REG_PC_LO = 2'h1;
  localparam logic [ADDR_W-1:0] REG_PC_HI = 2'h2;
  localparam logic [ADDR_W-1:0] REG_STATE = 2'h3;
  localparam logic [DATA_W-1:0] FLAGS_RST = 8'h00;
  localparam logic [PC_W-1:0]   PC_RST    = 16'h0000;

  // ***************************************************
  // Cycle counts per operation
  // ***************************************************
  localparam logic [CNT_W-1:0] CYC_PTR_CALL = 3'h4;
  localparam logic [CNT_W-1:0] CYC_ABS_CALL = 3'h5;
  localparam logic [CNT_W-1:0] CYC_RETURN   = 3'h5;
  localparam logic [CNT_W-1:0] CYC_ONE      = 3'h1;
  localparam logic [CNT_W-1:0] CYC_TWO      = 3'h2;
  localparam logic [CNT_W-1:0] CYC_THREE    = 3'h3;

  // ***************************************************
  // Program counter steps
  // ***************************************************
  localparam logic [PC_W-1:0] STEP_ONE   = 16'h0001;
  localparam logic [PC_W-1:0] STEP_TWO   = 16'h0002;
  localparam logic [PC_W-1:0] STEP_THREE = 16'h0003;

  // ***************************************************
  // Operation codes presented by the decoder
  // ***************************************************
  typedef enum logic [3:0] {
    OP_PTR_CALL    = 4'h0, // pointer_indirect_subroutine_jump
    OP_ABS_CALL    = 4'h1, // direct subroutine call
    OP_SUB_EXIT    = 4'h2, // subroutine_exit
    OP_INT_EXIT    = 4'h3, // interrupt_exit
    OP_CMP_SKIP    = 4'h4, // compare_skip_on_match
    OP_CMP         = 4'h5, // register_compare
    OP_CMP_CARRY   = 4'h6, // compare_with_carry_in
    OP_CMP_IMM     = 4'h7, // compare_with_immediate
    OP_SKIP_R_ZERO = 4'h8, // skip_reg_bit_zero
    OP_SKIP_R_ONE  = 4'h9, // skip_reg_bit_one
    OP_SKIP_IO_ZERO = 4'ha, // skip_io_bit_zero
    OP_SKIP_IO_ONE = 4'hb, // skip_io_bit_one
    OP_BR_FLAG_ONE = 4'hc, // branch_on_flag_one
    OP_BR_FLAG_ZERO = 4'hd, // branch_on_flag_zero
    OP_BR_ZERO     = 4'he, // branch_on_zero_flag
    OP_BR_NONZERO  = 4'hf  // branch_on_nonzero
  } csbf_op_t;

  // ***************************************************
  // Sequencer states
  // ***************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } csbf_state_t;

endpackage

// file: design/csbf_cmp.sv
// Eight-bit compare: subtract without storing and derive status flags
`timescale 1ns/1ps
module csbf_cmp (
  input  wire logic [7:0] op_a,
  input  wire logic [7:0] op_b,
  input  wire logic       carry_in,
  input  wire logic       use_carry,
  input  wire logic       zero_in,
  output logic            flag_c,
  output logic            flag_z,
  output logic            flag_n,
  output logic            flag_v,
  output logic            flag_s,
  output logic            flag_h
);

  logic [7:0] diff;
  logic       cin;

  // Difference, borrow included only for the carry variant
  assign cin  = use_carry & carry_in;
  assign diff = op_a - op_b - {7'h00, cin};

  // Borrow, overflow and sign flags from operand and result bits
  assign flag_h = (~op_a[3] & op_b[3]) | (op_b[3] & diff[3])
                | (diff[3] & ~op_a[3]);
  assign flag_c = (~op_a[7] & op_b[7]) | (op_b[7] & diff[7])
                | (diff[7] & ~op_a[7]);
  assign flag_v = (op_a[7] & ~op_b[7] & ~diff[7])
                | (~op_a[7] & op_b[7] & diff[7]);
  assign flag_n = diff[7];
  assign flag_s = flag_n ^ flag_v;
  // Carry variant keeps zero only if it was already set
  assign flag_z = (diff == 8'h00) & (~use_carry | zero_in);

endmodule

// file: design/csbf_flow.sv
// Control-flow execution unit: calls, returns, compares, skips, branches
//
// Summary of operation
// RL1 - Pointer call loads pointer, four cycles
// RL2 - Direct call loads absolute target, five cycles
// RL3 - Subroutine exit pops counter, five cycles
// RL4 - Interrupt exit pops counter, sets I
// RL5 - Compare equal skips next, flags untouched
// RL6 - Compares update Z N V C H, one cycle
// RL7 - Skip when register bit is zero
// RL8 - Skip when register bit is one
// RL9 - Skip when I/O bit is zero
// RL10 - Skip when I/O bit is one
// RL11 - Branch by offset plus one on flag one
// RL12 - Branch by offset plus one on flag zero
// RL13 - Branch when zero flag is one
// RL14 - Branch when zero flag is zero
// RL15 - Skip adds two or three, cycle per word
`timescale 1ns/1ps
module csbf_flow #(
  parameter int PC_W   = csbf_pkg::PC_W,
  parameter int DATA_W = csbf_pkg::DATA_W,
  parameter int OFF_W  = csbf_pkg::OFF_W
) (
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic                   op_valid,
  input  wire csbf_pkg::csbf_op_t     op_code,
  input  wire logic [DATA_W-1:0]      reg_a,
  input  wire logic [DATA_W-1:0]      reg_b,
  input  wire logic [DATA_W-1:0]      imm_value,
  input  wire logic [DATA_W-1:0]      io_value,
  input  wire logic [2:0]             bit_sel,
  input  wire logic [OFF_W-1:0]       branch_offset,
  input  wire logic [PC_W-1:0]        call_target,
  input  wire logic [PC_W-1:0]        pointer_value,
  input  wire logic [PC_W-1:0]        stack_value,
  input  wire logic                   next_is_long,
  input  wire logic [1:0]             reg_addr,
  input  wire logic [DATA_W-1:0]      reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [DATA_W-1:0]      reg_rdata,
  output logic                        op_ready,
  output logic                        op_done,
  output logic      [PC_W-1:0]        pc,
  output logic      [DATA_W-1:0]      status_flags_word,
  output logic                        push_valid,
  output logic      [PC_W-1:0]        push_value,
  output logic                        pop_valid
);

  // ***************************************************
  // Declarations
  // ***************************************************
  csbf_pkg::csbf_state_t state;
  logic [csbf_pkg::CNT_W-1:0] cnt;
  logic [PC_W-1:0]            pending_pc;
  logic                       pending_int;
  logic [csbf_pkg::CNT_W-1:0] next_cycles;
  logic [PC_W-1:0]            next_pc;
  logic                       next_int;
  logic                       next_flags_we;
  logic                       next_push;
  logic                       next_pop;
  logic [PC_W-1:0]            next_push_value;
  logic                       accept;
  logic                       take;
  logic [DATA_W-1:0]          cmp_b;
  logic                       cmp_carry;
  logic                       c_c;
  logic                       c_z;
  logic                       c_n;
  logic                       c_v;
  logic                       c_s;
  logic                       c_h;

  // ***************************************************
  // Helpers
  // ***************************************************

  // Skip distance grows with the length of the next instruction
  function automatic logic [PC_W-1:0] skip_step(input logic long_next);
    skip_step = long_next ? csbf_pkg::STEP_THREE : csbf_pkg::STEP_TWO;
  endfunction

  // Skip costs one extra cycle per skipped word
  function automatic logic [csbf_pkg::CNT_W-1:0] skip_cycles(
    input logic long_next);
    skip_cycles = long_next ? csbf_pkg::CYC_THREE : csbf_pkg::CYC_TWO;
  endfunction

  // Relative target: counter plus sign-extended offset plus one
  function automatic logic [PC_W-1:0] rel_target(
    input logic [PC_W-1:0]  base,
    input logic [OFF_W-1:0] off);
    logic [PC_W-1:0] ext;
    ext = {{(PC_W-OFF_W){off[OFF_W-1]}}, off};
    rel_target = base + ext + csbf_pkg::STEP_ONE;
  endfunction

  // ***************************************************
  // Compare datapath
  // ***************************************************

  // Immediate compare uses the constant as subtrahend
  assign cmp_b = (op_code == csbf_pkg::OP_CMP_IMM) ? imm_value : reg_b;
  assign cmp_carry = (op_code == csbf_pkg::OP_CMP_CARRY);

  csbf_cmp u_cmp (
    .op_a      (reg_a),
    .op_b      (cmp_b),
    .carry_in  (status_flags_word[csbf_pkg::FLAG_C]),
    .use_carry (cmp_carry),
    .zero_in   (status_flags_word[csbf_pkg::FLAG_Z]),
    .flag_c    (c_c),
    .flag_z    (c_z),
    .flag_n    (c_n),
    .flag_v    (c_v),
    .flag_s    (c_s),
    .flag_h    (c_h)
  );

  // ***************************************************
  // Operation decode
  // ***************************************************

  assign op_ready = (state == csbf_pkg::ST_IDLE);
  assign accept   = op_valid & op_ready;

  // Target counter, cycle cost and side effects per operation
  always_comb begin
    next_cycles     = csbf_pkg::CYC_ONE;
    next_pc         = pc + csbf_pkg::STEP_ONE;
    next_int        = 1'b0;
    next_flags_we   = 1'b0;
    next_push       = 1'b0;
    next_pop        = 1'b0;
    next_push_value = pc + csbf_pkg::STEP_ONE;
    take            = 1'b0;
    unique case (op_code)
      csbf_pkg::OP_PTR_CALL: begin
        next_pc     = pointer_value; // RL1
        next_cycles = csbf_pkg::CYC_PTR_CALL; // RL1
        next_push   = 1'b1;
      end
      csbf_pkg::OP_ABS_CALL: begin
        next_pc         = call_target; // RL2
        next_cycles     = csbf_pkg::CYC_ABS_CALL; // RL2
        next_push       = 1'b1;
        next_push_value = pc + csbf_pkg::STEP_TWO;
      end
      csbf_pkg::OP_SUB_EXIT: begin
        next_pc     = stack_value; // RL3
        next_cycles = csbf_pkg::CYC_RETURN; // RL3
        next_pop    = 1'b1;
      end
      csbf_pkg::OP_INT_EXIT: begin
        next_pc     = stack_value; // RL4
        next_cycles = csbf_pkg::CYC_RETURN; // RL4
        next_pop    = 1'b1;
        next_int    = 1'b1; // RL4
      end
      csbf_pkg::OP_CMP_SKIP: begin
        take = (reg_a == reg_b); // RL5
      end
      csbf_pkg::OP_CMP, csbf_pkg::OP_CMP_CARRY,
      csbf_pkg::OP_CMP_IMM: begin
        next_flags_we = 1'b1; // RL6
      end
      csbf_pkg::OP_SKIP_R_ZERO: begin
        take = ~reg_a[bit_sel]; // RL7
      end
      csbf_pkg::OP_SKIP_R_ONE: begin
        take = reg_a[bit_sel]; // RL8
      end
      csbf_pkg::OP_SKIP_IO_ZERO: begin
        take = ~io_value[bit_sel]; // RL9
      end
      csbf_pkg::OP_SKIP_IO_ONE: begin
        take = io_value[bit_sel]; // RL10
      end
      csbf_pkg::OP_BR_FLAG_ONE: begin
        take = status_flags_word[bit_sel]; // RL11
      end
      csbf_pkg::OP_BR_FLAG_ZERO: begin
        take = ~status_flags_word[bit_sel]; // RL12
      end
      csbf_pkg::OP_BR_ZERO: begin
        take = status_flags_word[csbf_pkg::FLAG_Z]; // RL13
      end
      csbf_pkg::OP_BR_NONZERO: begin
        take = ~status_flags_word[csbf_pkg::FLAG_Z]; // RL14
      end
    endcase
    // Taken skip steps over one or two words
    if (take && op_code >= csbf_pkg::OP_CMP_SKIP &&
        op_code <= csbf_pkg::OP_SKIP_IO_ONE) begin
      next_pc     = pc + skip_step(next_is_long); // RL15
      next_cycles = skip_cycles(next_is_long); // RL15
    end
    // Taken branch jumps relative and costs one extra cycle
    if (take && op_code >= csbf_pkg::OP_BR_FLAG_ONE) begin
      next_pc     = rel_target(pc, branch_offset); // RL11
      next_cycles = csbf_pkg::CYC_TWO; // RL12
    end
  end

  // ***************************************************
  // Sequencer
  // ***************************************************

  // Multi-cycle operations wait until their last cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= csbf_pkg::ST_IDLE;
      cnt   <= '0;
    end else begin
      unique case (state)
        csbf_pkg::ST_IDLE: begin
          if (accept && next_cycles != csbf_pkg::CYC_ONE) begin
            state <= csbf_pkg::ST_WAIT;
            cnt   <= next_cycles - csbf_pkg::CYC_TWO;
          end
        end
        csbf_pkg::ST_WAIT: begin
          if (cnt == '0) begin
            state <= csbf_pkg::ST_IDLE;
          end else begin
            cnt <= cnt - csbf_pkg::CYC_ONE;
          end
        end
      endcase
    end
  end

  // Target held while a multi-cycle operation runs
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pending_pc  <= csbf_pkg::PC_RST;
      pending_int <= 1'b0;
    end else if (accept) begin
      pending_pc  <= next_pc;
      pending_int <= next_int;
    end
  end

  // ***************************************************
  // Program counter and completion
  // ***************************************************

  // Counter changes in the last cycle of each operation
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pc      <= csbf_pkg::PC_RST;
      op_done <= 1'b0;
    end else begin
      op_done <= 1'b0;
      if (accept && next_cycles == csbf_pkg::CYC_ONE) begin
        pc      <= next_pc;
        op_done <= 1'b1;
      end else if (state == csbf_pkg::ST_WAIT && cnt == '0) begin
        pc      <= pending_pc;
        op_done <= 1'b1;
      end else if (reg_wr && op_ready && reg_addr == csbf_pkg::REG_PC_LO)
      begin
        pc[7:0] <= reg_wdata;
      end else if (reg_wr && op_ready && reg_addr == csbf_pkg::REG_PC_HI)
      begin
        pc[PC_W-1:8] <= reg_wdata[PC_W-9:0];
      end
    end
  end

  // Stack requests: call pushes return address, exits pop
  always_ff @(posedge clk) begin
    if (!rstn) begin
      push_valid <= 1'b0;
      push_value <= csbf_pkg::PC_RST;
      pop_valid  <= 1'b0;
    end else begin
      push_valid <= accept & next_push;
      pop_valid  <= accept & next_pop;
      if (accept && next_push) begin
        push_value <= next_push_value;
      end
    end
  end

  // ***************************************************
  // Status flags
  // ***************************************************

  // Compare result wins over a software write in the same cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      status_flags_word <= csbf_pkg::FLAGS_RST;
    end else if (accept && next_flags_we) begin
      status_flags_word[csbf_pkg::FLAG_C] <= c_c; // RL6
      status_flags_word[csbf_pkg::FLAG_Z] <= c_z; // RL6
      status_flags_word[csbf_pkg::FLAG_N] <= c_n; // RL6
      status_flags_word[csbf_pkg::FLAG_V] <= c_v; // RL6
      status_flags_word[csbf_pkg::FLAG_S] <= c_s;
      status_flags_word[csbf_pkg::FLAG_H] <= c_h; // RL6
    end else if (state == csbf_pkg::ST_WAIT && cnt == '0 && pending_int)
    begin
      status_flags_word[csbf_pkg::FLAG_I] <= 1'b1; // RL4
    end else if (reg_wr && reg_addr == csbf_pkg::REG_FLAGS) begin
      status_flags_word <= reg_wdata;
    end
  end

  // ***************************************************
  // Register read port
  // ***************************************************

  // Read data stands in the cycle after the read strobe only
  always_ff @(posedge clk) begin
    if (!rstn) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        csbf_pkg::REG_FLAGS: reg_rdata <= status_flags_word;
        csbf_pkg::REG_PC_LO: reg_rdata <= pc[7:0];
        csbf_pkg::REG_PC_HI: reg_rdata <= pc[PC_W-1:8];
        csbf_pkg::REG_STATE: reg_rdata <= {3'h0, cnt, state};
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule

// file: sim/csbf_flow_asserts.sv
// Concurrent checks on the ports of the control-flow unit
`timescale 1ns/1ps
module csbf_flow_chk (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic               op_valid,
  input  wire csbf_pkg::csbf_op_t op_code,
  input  wire logic               reg_wr,
  input  wire logic [2:0]         bit_sel,
  input  wire logic [6:0]         branch_offset,
  input  wire logic [15:0]        call_target,
  input  wire logic [15:0]        pointer_value,
  input  wire logic [15:0]        stack_value,
  input  wire logic               op_ready,
  input  wire logic               op_done,
  input  wire logic [15:0]        pc,
  input  wire logic [7:0]         status_flags_word,
  input  wire logic               push_valid,
  input  wire logic [15:0]        push_value,
  input  wire logic               pop_valid
);
  logic        acc;
  logic [15:0] soff;
  // Accept strobe and sign-extended branch offset
  assign acc  = op_valid & op_ready;
  assign soff = {{9{branch_offset[6]}}, branch_offset};

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  a_ptr_call_time: assert property (
    acc && op_code == csbf_pkg::OP_PTR_CALL |=> !op_ready [*3] ##1
    (op_done && pc == $past(pointer_value, 4)))
    else $error("pointer call timing or target wrong");
  a_abs_call_time: assert property (
    acc && op_code == csbf_pkg::OP_ABS_CALL |=> !op_ready [*4] ##1
    (op_done && pc == $past(call_target, 5)))
    else $error("direct call timing or target wrong");
  a_exit_time: assert property (
    acc && op_code inside {csbf_pkg::OP_SUB_EXIT, csbf_pkg::OP_INT_EXIT}
    |=> !op_ready [*4] ##1 (op_done && pc == $past(stack_value, 5)))
    else $error("exit timing or return address wrong");
  a_int_exit_flag: assert property (
    acc && op_code == csbf_pkg::OP_INT_EXIT |-> ##5
    status_flags_word[csbf_pkg::FLAG_I])
    else $error("interrupt exit left enable flag clear");
  a_push_addr: assert property (
    acc && op_code inside {csbf_pkg::OP_PTR_CALL, csbf_pkg::OP_ABS_CALL}
    |=> push_valid && push_value == $past(pc) +
    (($past(op_code) == csbf_pkg::OP_PTR_CALL) ? 16'h0001 : 16'h0002))
    else $error("return address push wrong");
  a_exit_pop: assert property (
    acc && op_code inside {csbf_pkg::OP_SUB_EXIT, csbf_pkg::OP_INT_EXIT}
    |=> pop_valid)
    else $error("exit did not pop");
  a_cmp_single: assert property (
    acc && op_code inside {csbf_pkg::OP_CMP, csbf_pkg::OP_CMP_CARRY,
    csbf_pkg::OP_CMP_IMM} |=> op_done && op_ready)
    else $error("compare not single cycle");
  a_skip_flags: assert property (
    acc && !reg_wr && op_code inside {csbf_pkg::OP_CMP_SKIP,
    csbf_pkg::OP_SKIP_R_ZERO, csbf_pkg::OP_SKIP_R_ONE,
    csbf_pkg::OP_SKIP_IO_ZERO, csbf_pkg::OP_SKIP_IO_ONE}
    |=> $stable(status_flags_word))
    else $error("skip altered flags");
  a_branch_taken: assert property (
    acc && op_code == csbf_pkg::OP_BR_FLAG_ONE && status_flags_word[bit_sel]
    |=> !op_ready ##1
    (op_done && pc == $past(pc, 2) + $past(soff, 2) + 16'h0001))
    else $error("taken branch target or timing wrong");
  a_branch_not_taken: assert property (
    acc && op_code == csbf_pkg::OP_BR_FLAG_ZERO && status_flags_word[bit_sel]
    |=> op_done && pc == $past(pc) + 16'h0001)
    else $error("untaken branch wrong");
endmodule

// file: sim/csbf_stack_model.sv
// Return address store standing in for the stack beside the core
`timescale 1ns/1ps
module csbf_stack_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        push_valid,
  input  wire logic [15:0] push_value,
  input  wire logic        pop_valid,
  output logic      [15:0] stack_value
);
  logic [15:0] mem [8];
  logic [3:0]  sp;
  logic        tog;
  // Store on push, drop on pop
  always @(posedge clk) begin
    tog <= rstn ? ~tog : 1'b0;
    if (!rstn) sp <= 4'h0;
    else if (push_valid) begin
      mem[sp[2:0]] <= push_value;
      sp <= sp + 4'h1;
    end
    else if (pop_valid && sp != 4'h0) sp <= sp - 4'h1;
  end
  // Empty store shows a changing pattern, never a stale address
  assign stack_value = (sp != 4'h0) ? mem[sp[2:0] - 3'h1]
                                    : ({16{tog}} ^ 16'h5a5a);
endmodule

// file: sim/test_compare_skip_branch_flow.sv
// Self-checking bench for the compare, skip and branch flow unit
`timescale 1ns/1ps
module test_compare_skip_branch_flow;
  typedef struct {logic [15:0] pc; logic [7:0] fl; logic [15:0] cyc;}
    csbf_note_t;
  logic clk = 1'b0;
  logic rstn, op_valid, next_is_long, reg_wr, reg_rd;
  logic op_ready, op_done, push_valid, pop_valid;
  csbf_pkg::csbf_op_t op_code;
  csbf_pkg::csbf_op_t cl [3];
  csbf_pkg::csbf_op_t sl [5];
  csbf_pkg::csbf_op_t bl [4];
  logic [7:0]  reg_a, reg_b, imm_value, io_value, reg_wdata, reg_rdata;
  logic [7:0]  status_flags_word, efl, ra, rb;
  logic [2:0]  bit_sel;
  logic [6:0]  branch_offset;
  logic [15:0] call_target, pointer_value, stack_value, pc, push_value;
  logic [15:0] epc, cnt;
  logic [1:0]  reg_addr;
  logic [15:0] rq [$];
  csbf_note_t  notes [$];
  csbf_note_t  mn;
  int          failures, comparisons, i;

  csbf_flow dut (.*);
  csbf_stack_model model (.*);

  // ***************************************************
  // Clock, checking and closing
  // ***************************************************
  always #20 clk = ~clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Compare flags from widened subtractions: borrows out of the byte
  // and the low nibble, overflow from the operand and result signs
  function automatic logic [7:0] cmpf(input logic [7:0] a, b,
                                      input logic ci, kz);
    logic [8:0] w;
    logic [4:0] q;
    logic       v;
    w = {1'b0, a} - {1'b0, b} - {8'h00, ci};
    q = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
    v = (a[7] != b[7]) && (w[7] != a[7]);
    return {efl[7:6], q[4], w[7] ^ v, v, w[7],
            (w[7:0] == 8'h00) && (!kz || efl[1]), w[8]};
  endfunction

  // ***************************************************
  // Drivers
  // ***************************************************
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check({8'h00, reg_rdata}, {8'h00, e});
    @(posedge clk);
  endtask

  // Offer one operation, note its outcome, return right after the clock edge at which it is accepted
  task automatic op(input csbf_pkg::csbf_op_t o, input logic [7:0] a, b,
                    input logic [2:0] bs, input logic [6:0] k,
                    input logic [15:0] t, input logic lg);
    logic       sk, tk, io;
    csbf_note_t n;
    io = o inside {csbf_pkg::OP_SKIP_IO_ZERO, csbf_pkg::OP_SKIP_IO_ONE};
    op_code <= o;
    reg_a <= io ? ~a : a;
    io_value <= io ? a : ~a;
    reg_b <= (o == csbf_pkg::OP_CMP_IMM) ? ~b : b;
    imm_value <= (o == csbf_pkg::OP_CMP_IMM) ? b : ~b;
    bit_sel <= bs;
    branch_offset <= k;
    call_target <= (o == csbf_pkg::OP_ABS_CALL) ? t : ~t;
    pointer_value <= (o == csbf_pkg::OP_PTR_CALL) ? t : ~t;
    next_is_long <= lg;
    op_valid <= 1'b1;
    sk = 1'b0;
    tk = 1'b0;
    n.cyc = 16'h0001;
    case (o)
      csbf_pkg::OP_PTR_CALL: begin
        rq.push_back(epc + 16'h0001);
        epc = t;
        n.cyc = 16'h0004;
      end
      csbf_pkg::OP_ABS_CALL: begin
        rq.push_back(epc + 16'h0002);
        epc = t;
        n.cyc = 16'h0005;
      end
      csbf_pkg::OP_SUB_EXIT, csbf_pkg::OP_INT_EXIT: begin
        epc = rq.pop_back();
        n.cyc = 16'h0005;
        if (o == csbf_pkg::OP_INT_EXIT) efl[7] = 1'b1;
      end
      csbf_pkg::OP_CMP, csbf_pkg::OP_CMP_IMM: efl = cmpf(a, b, 0, 0);
      csbf_pkg::OP_CMP_CARRY: efl = cmpf(a, b, efl[0], 1);
      csbf_pkg::OP_CMP_SKIP: sk = (a == b);
      csbf_pkg::OP_SKIP_R_ZERO, csbf_pkg::OP_SKIP_IO_ZERO: sk = !a[bs];
      csbf_pkg::OP_SKIP_R_ONE, csbf_pkg::OP_SKIP_IO_ONE: sk = a[bs];
      csbf_pkg::OP_BR_FLAG_ONE: tk = efl[bs];
      csbf_pkg::OP_BR_FLAG_ZERO: tk = !efl[bs];
      csbf_pkg::OP_BR_ZERO: tk = efl[1];
      default: tk = !efl[1];
    endcase
    if (tk) begin
      epc = epc + {{9{k[6]}}, k} + 16'h0001;
      n.cyc = 16'h0002;
    end
    else if (sk) begin
      epc = epc + (lg ? 16'h0003 : 16'h0002);
      n.cyc = lg ? 16'h0003 : 16'h0002;
    end
    else if (n.cyc == 16'h0001) epc = epc + 16'h0001;
    n.pc = epc;
    n.fl = efl;
    notes.push_back(n);
    do @(posedge clk); while (op_ready !== 1'b1);
  endtask

  // ***************************************************
  // Result watcher
  // ***************************************************
  always @(posedge clk) begin
    if (rstn && op_done === 1'b1) begin
      if (notes.size() == 0) begin
        failures++;
        $display("[ERR] %0t completion with nothing pending", $time);
      end
      else begin
        mn = notes.pop_front();
        check(pc, mn.pc);
        check({8'h00, status_flags_word}, {8'h00, mn.fl});
        check(cnt, mn.cyc);
      end
    end
    cnt = (op_valid && op_ready) ? 16'h0001 : cnt + 16'h0001;
  end

  // ***************************************************
  // Main sequence and watchdog
  // ***************************************************
  initial begin
    rstn = 0; op_valid = 0; next_is_long = 0; reg_wr = 0;
    reg_rd = 0; op_code = csbf_pkg::OP_CMP; reg_a = 0; reg_b = 0;
    imm_value = 0; io_value = 0; reg_wdata = 0; bit_sel = 0;
    branch_offset = 0; call_target = 0; pointer_value = 0; reg_addr = 0;
    failures = 0; comparisons = 0; cnt = 0; epc = 0; efl = 0;
    cl = '{csbf_pkg::OP_CMP, csbf_pkg::OP_CMP_CARRY, csbf_pkg::OP_CMP_IMM};
    sl = '{csbf_pkg::OP_CMP_SKIP, csbf_pkg::OP_SKIP_R_ZERO,
           csbf_pkg::OP_SKIP_R_ONE, csbf_pkg::OP_SKIP_IO_ZERO,
           csbf_pkg::OP_SKIP_IO_ONE};
    bl = '{csbf_pkg::OP_BR_FLAG_ONE, csbf_pkg::OP_BR_FLAG_ZERO,
           csbf_pkg::OP_BR_ZERO, csbf_pkg::OP_BR_NONZERO};
    void'($urandom(81505));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(2'h0, 8'h00);
    rd(2'h1, 8'h00);
    rd(2'h3, 8'h01);
    wr(2'h2, 8'h12);
    wr(2'h1, 8'h34);
    rd(2'h2, 8'h12);
    rd(2'h1, 8'h34);
    epc = 16'h1234;
    // Nested calls, then both exits back to back
    op(csbf_pkg::OP_PTR_CALL, 0, 0, 0, 0, 16'h0200, 0);
    op(csbf_pkg::OP_ABS_CALL, 0, 0, 0, 0, 16'h3000, 0);
    op(csbf_pkg::OP_INT_EXIT, 0, 0, 0, 0, 16'h0000, 0);
    op(csbf_pkg::OP_SUB_EXIT, 0, 0, 0, 0, 16'h0000, 0);
    for (i = 0; i < 24; i++) begin
      ra = 8'($urandom);
      rb = (i % 4 == 0) ? ra : 8'($urandom);
      op(cl[i % 3], ra, rb, 0, 0, 0, 0);
    end
    for (i = 0; i < 40; i++) begin
      ra = 8'($urandom);
      rb = i[0] ? ra : 8'($urandom);
      op(sl[i % 5], ra, rb, 3'($urandom), 0, 0, 1'($urandom));
    end
    for (i = 0; i < 32; i++) begin
      op_valid <= 1'b0;
      repeat (3) @(posedge clk);
      ra = 8'($urandom);
      wr(2'h0, ra);
      efl = ra;
      op(bl[i % 4], 0, 0, 3'($urandom), 7'($urandom), 0, 0);
    end
    op_valid <= 1'b0;
    repeat (8) @(posedge clk);
    rd(2'h3, 8'h01);
    check(16'(notes.size()), 16'h0000);
    finish_test;
  end

  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test;
  end
endmodule

bind csbf_flow csbf_flow_chk chk (.*);
